/* File: hw/qrw_ctrl.v */
`timescale 1ns/1ps
`include "qrw_regs.vh"

// Functional notes
// - word quad read needs quad enable set
// - word quad read: two dummy clocks
// - mode byte captured, upper nibble evaluated
// - mode nibble A: next frame skips opcode
// - other mode nibble: next frame needs opcode
// - wrap within aligned section until deselect
// - set-wrap refused without quad enable
// - set-wrap: opcode, 24 dummy, 8 wrap bits
// - wrap length 8/16/32/64, disable bit default set
// - wrap setting applies to later quad reads
// - qpi burst wrap read like fast read
// - qpi parameters set dummies and wrap length
// - parameter command ignored in serial mode
// - wrap length kept across mode switch
// - defaults: 8-byte wrap, 4 dummy clocks
// - software reset restores volatile defaults
// - reset only directly after reset enable
// - no command accepted during reset recovery
module qrw_ctrl #(
  parameter RESET_RECOVERY_CYCLES = `QRW_RST_CYCLES
) (
  // clock and reset
  input  wire        MCLK,
  input  wire        RESETN,
  // serial link pins
  input  wire        CS_N,
  input  wire        SCK,
  input  wire [3:0]  IO_IN,
  output reg  [3:0]  IO_OUT,
  output reg  [3:0]  IO_OE_N,
  // status inputs
  input  wire        QUAD_ENABLE,
  input  wire        QPI_MODE,
  // array read port
  output reg  [23:0] ARRAY_ADDR,
  input  wire [7:0]  ARRAY_DATA,
  output reg         ARRAY_RD,
  // configuration and state
  output reg         WRAP_DISABLE,
  output reg  [1:0]  WRAP_LENGTH,
  output reg  [1:0]  DUMMY_SELECT,
  output reg         CONT_READ,
  output reg         SW_RESET,
  output wire        RESET_BUSY
);

  // ==========================================================
  // constants
  localparam RCW = $clog2(RESET_RECOVERY_CYCLES + 1);
  localparam [RCW-1:0] RCV_LOAD = RESET_RECOVERY_CYCLES[RCW-1:0];

  localparam [3:0] ST_IDLE  = 4'h0;
  localparam [3:0] ST_OPC   = 4'h1;
  localparam [3:0] ST_ADDR  = 4'h2;
  localparam [3:0] ST_MODE  = 4'h3;
  localparam [3:0] ST_DUMMY = 4'h4;
  localparam [3:0] ST_DATA  = 4'h5;
  localparam [3:0] ST_WRAPB = 4'h6;
  localparam [3:0] ST_PARAM = 4'h7;
  localparam [3:0] ST_SKIP  = 4'h8;

  // ==========================================================
  // functions
  function [5:0] dummy_clocks;
    input [1:0] sel;
    begin
      case (sel)
        2'h2:    dummy_clocks = `QRW_DUMMY_MID;
        2'h3:    dummy_clocks = `QRW_DUMMY_HIGH;
        default: dummy_clocks = `QRW_DUMMY_LOW;
      endcase
    end
  endfunction

  function [3:0] first_state;
    input [7:0] op;
    input       quad_instruction_mode;
    input       qe;
    begin
      case (op)
        `QRW_OP_WORD_QREAD: first_state = (qe && !quad_instruction_mode) ? ST_ADDR : ST_SKIP;
        `QRW_OP_FAST_QREAD: first_state = qe ? ST_ADDR : ST_SKIP;
        `QRW_OP_FAST_READ:  first_state = quad_instruction_mode ? ST_ADDR : ST_SKIP;
        `QRW_OP_BURST_WRAP: first_state = quad_instruction_mode ? ST_ADDR : ST_SKIP;
        `QRW_OP_SET_WRAP:   first_state = qe ? ST_WRAPB : ST_SKIP;
        `QRW_OP_SET_PARAM:  first_state = quad_instruction_mode ? ST_PARAM : ST_SKIP;
        default:            first_state = ST_SKIP;
      endcase
    end
  endfunction

  function [5:0] phase_clocks;
    input [3:0] st;
    begin
      case (st)
        ST_ADDR:  phase_clocks = `QRW_CLK_ADDR;
        ST_WRAPB: phase_clocks = `QRW_CLK_SET_WRAP;
        ST_PARAM: phase_clocks = `QRW_CLK_PARAM;
        default:  phase_clocks = 6'h00;
      endcase
    end
  endfunction

  // next byte address, wrapping inside the aligned section
  function [23:0] next_addr;
    input [23:0] a;
    input        wrap;
    input [1:0]  len;
    reg   [6:0]  mask;
    reg   [23:0] inc;
    reg   [23:0] m24;
    begin
      mask = (7'h08 << len) - 7'h01;
      inc  = a + 24'h000001;
      m24  = {17'h0, mask};
      if (wrap)
        next_addr = (a & ~m24) | (inc & m24);
      else
        next_addr = inc;
    end
  endfunction

  // ==========================================================
  // pin synchronisation and edge finding
  wire [5:0] pins_sync;
  wire       s_cs_n;
  wire       s_sck;
  wire [3:0] s_io;

  qrw_sync #(
    .WIDTH (6)
  ) u_sync (
    .clk   (MCLK),
    .rst_n (RESETN),
    .d     ({CS_N, SCK, IO_IN}),
    .q     (pins_sync)
  );

  assign s_cs_n = pins_sync[5];
  assign s_sck  = pins_sync[4];
  assign s_io   = pins_sync[3:0];

  reg sck_d;
  reg cs_d;

  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      sck_d <= 1'b1; // synchroniser resets high: no false rise
      cs_d  <= 1'b1;
    end else begin
      sck_d <= s_sck;
      cs_d  <= s_cs_n;
    end
  end

  wire sck_rise = s_sck & ~sck_d;
  wire sck_fall = ~s_sck & sck_d;
  wire cs_fall  = ~s_cs_n & cs_d;

  // ==========================================================
  // frame state
  reg [3:0]     state;
  reg [5:0]     cnt;
  reg [7:0]     cmd;
  reg [31:0]    sh;
  reg           qpi_frame;
  reg [7:0]     cont_cmd;
  reg           armed;
  reg [3:0]     byte_lo;
  reg           nib;
  reg [RCW-1:0] rcnt;

  assign RESET_BUSY = (rcnt != {RCW{1'b0}});

  wire        last    = (cnt == 6'h01);
  wire [7:0]  op_spi  = {sh[6:0], s_io[0]};
  wire [7:0]  op_qpi  = {sh[3:0], s_io};
  wire [7:0]  op_now  = qpi_frame ? op_qpi : op_spi;
  wire [3:0]  op_st   = first_state(op_now, qpi_frame, QUAD_ENABLE);
  wire [7:0]  byte_q  = {sh[3:0], s_io};
  wire [23:0] addr_q  = {sh[19:0], s_io};
  wire        is_word = (cmd == `QRW_OP_WORD_QREAD);
  wire        is_fq   = (cmd == `QRW_OP_FAST_QREAD);
  wire        is_bw   = (cmd == `QRW_OP_BURST_WRAP);
  // burst wrap always wraps; quad io reads follow the wrap setting
  wire        wrap_on = is_bw | ((is_word | is_fq) & ~WRAP_DISABLE);

  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      state        <= ST_IDLE;
      cnt          <= 6'h00;
      cmd          <= 8'h00;
      sh           <= 32'h00000000;
      qpi_frame    <= 1'b0;
      cont_cmd     <= 8'h00;
      armed        <= 1'b0;
      byte_lo      <= 4'h0;
      nib          <= 1'b0;
      rcnt         <= {RCW{1'b0}};
      IO_OUT       <= 4'h0;
      IO_OE_N      <= 4'hf;
      ARRAY_ADDR   <= 24'h000000;
      ARRAY_RD     <= 1'b0;
      WRAP_DISABLE <= `QRW_RST_WRAP_DIS;
      WRAP_LENGTH  <= `QRW_RST_WRAP_LEN;
      DUMMY_SELECT <= `QRW_RST_DUMMY_SEL;
      CONT_READ    <= 1'b0;
      SW_RESET     <= 1'b0;
    end else begin
      ARRAY_RD <= 1'b0;
      SW_RESET <= 1'b0;
      if (RESET_BUSY)
        rcnt <= rcnt - {{(RCW-1){1'b0}}, 1'b1};
      if (s_cs_n) begin
        state   <= ST_IDLE;
        IO_OE_N <= 4'hf;
        nib     <= 1'b0;
      end else if (cs_fall) begin
        qpi_frame <= QPI_MODE;
        sh        <= 32'h00000000;
        if (RESET_BUSY) begin
          state <= ST_SKIP;
        end else if (CONT_READ) begin
          state <= ST_ADDR;
          cmd   <= cont_cmd;
          cnt   <= `QRW_CLK_ADDR;
        end else begin
          state <= ST_OPC;
          cnt   <= QPI_MODE ? `QRW_CLK_OPC_QPI : `QRW_CLK_OPC_SPI;
        end
      end else if (sck_rise) begin
        if (state == ST_OPC && !qpi_frame)
          sh <= {sh[30:0], s_io[0]};
        else
          sh <= {sh[27:0], s_io};
        if (cnt != 6'h00)
          cnt <= cnt - 6'h01;
        case (state)
          ST_OPC: begin
            if (last) begin
              cmd   <= op_now;
              armed <= (op_now == `QRW_OP_RST_EN);
              if (op_now == `QRW_OP_RST && armed) begin
                // abort everything and return to power-on values
                state        <= ST_SKIP;
                SW_RESET     <= 1'b1;
                rcnt         <= RCV_LOAD;
                CONT_READ    <= 1'b0;
                WRAP_DISABLE <= `QRW_RST_WRAP_DIS;
                WRAP_LENGTH  <= `QRW_RST_WRAP_LEN;
                DUMMY_SELECT <= `QRW_RST_DUMMY_SEL;
              end else begin
                state <= op_st;
                cnt   <= phase_clocks(op_st);
              end
            end
          end
          ST_ADDR: begin
            if (last) begin
              ARRAY_ADDR <= addr_q;
              if (is_word || is_fq) begin
                state <= ST_MODE;
                cnt   <= `QRW_CLK_MODE;
              end else begin
                state <= ST_DUMMY;
                cnt   <= dummy_clocks(DUMMY_SELECT);
              end
            end
          end
          ST_MODE: begin
            if (last) begin
              // only the upper nibble counts
              CONT_READ <= (byte_q[7:4] == `QRW_CONT_KEY);
              cont_cmd  <= cmd;
              state     <= ST_DUMMY;
              if (is_word)
                cnt <= `QRW_CLK_WORD_DUMMY;
              else if (qpi_frame)
                cnt <= dummy_clocks(DUMMY_SELECT) - `QRW_CLK_MODE;
              else
                cnt <= `QRW_CLK_FQ_DUMMY;
            end
          end
          ST_DUMMY: begin
            if (last) begin
              state <= ST_DATA;
              nib   <= 1'b0;
            end
          end
          ST_WRAPB: begin
            if (last) begin
              // bit 7 and bits 3..0 are dropped
              WRAP_DISABLE <= byte_q[`QRW_W_DIS_BIT];
              WRAP_LENGTH  <= byte_q[`QRW_W_LEN_HI:`QRW_W_LEN_LO];
              state        <= ST_SKIP;
            end
          end
          ST_PARAM: begin
            if (last) begin
              DUMMY_SELECT <= byte_q[`QRW_P_DUMMY_HI:`QRW_P_DUMMY_LO];
              WRAP_LENGTH  <= byte_q[`QRW_P_WLEN_HI:`QRW_P_WLEN_LO];
              state        <= ST_SKIP;
            end
          end
          ST_IDLE, ST_DATA, ST_SKIP: begin
            state <= state;
          end
          default: begin
            state <= ST_SKIP;
          end
        endcase
      end else if (sck_fall && state == ST_DATA) begin
        // host has released the lines by now
        IO_OE_N <= 4'h0;
        if (!nib) begin
          IO_OUT  <= ARRAY_DATA[7:4];
          byte_lo <= ARRAY_DATA[3:0];
          nib     <= 1'b1;
        end else begin
          IO_OUT     <= byte_lo;
          nib        <= 1'b0;
          ARRAY_RD   <= 1'b1;
          ARRAY_ADDR <= next_addr(ARRAY_ADDR, wrap_on, WRAP_LENGTH);
        end
      end
    end
  end

endmodule

/* File: common/qrw_regs.vh */
`ifndef QRW_REGS_VH
`define QRW_REGS_VH

// ==========================================================
// opcodes
`define QRW_OP_WORD_QREAD   8'he7
`define QRW_OP_FAST_QREAD   8'heb
`define QRW_OP_FAST_READ    8'h0b
`define QRW_OP_BURST_WRAP   8'h0c
`define QRW_OP_SET_WRAP     8'h77
`define QRW_OP_SET_PARAM    8'hc0
`define QRW_OP_RST_EN       8'h66
`define QRW_OP_RST          8'h99

// ==========================================================
// field positions
`define QRW_CONT_KEY        4'ha
`define QRW_W_DIS_BIT       4
`define QRW_W_LEN_HI        6
`define QRW_W_LEN_LO        5
`define QRW_P_DUMMY_HI      5
`define QRW_P_DUMMY_LO      4
`define QRW_P_WLEN_HI       1
`define QRW_P_WLEN_LO       0

// ==========================================================
// reset values
`define QRW_RST_WRAP_DIS    1'b1
`define QRW_RST_WRAP_LEN    2'h0
`define QRW_RST_DUMMY_SEL   2'h0

// ==========================================================
// serial clock counts per phase
`define QRW_CLK_OPC_SPI     6'h08
`define QRW_CLK_OPC_QPI     6'h02
`define QRW_CLK_ADDR        6'h06
`define QRW_CLK_MODE        6'h02
`define QRW_CLK_WORD_DUMMY  6'h02
`define QRW_CLK_FQ_DUMMY    6'h04
`define QRW_CLK_SET_WRAP    6'h08
`define QRW_CLK_PARAM       6'h02
`define QRW_DUMMY_LOW       6'h04
`define QRW_DUMMY_MID       6'h06
`define QRW_DUMMY_HIGH      6'h08

// ==========================================================
// timing
`define QRW_MCLK_PERIOD_PS  5000
`define QRW_T_RST_US        30
`define QRW_RST_CYCLES      ((`QRW_T_RST_US * 1000000 + `QRW_MCLK_PERIOD_PS - 1) / `QRW_MCLK_PERIOD_PS)

`endif

/* File: hw/qrw_sync.v */
`timescale 1ns/1ps
// ==========================================================
// two-stage synchroniser, stage one feeds stage two only
module qrw_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] d,
  output reg  [WIDTH-1:0] q
);
  reg [WIDTH-1:0] meta;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= {WIDTH{1'b1}};
      q    <= {WIDTH{1'b1}};
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

/* File: bench/qrw_host.sv */
`timescale 1ns/1ps
// ==========================================================
// host controller model, sck stands still between frames
module qrw_host (
  // link pins
  output reg       cs_n,
  output reg       sck,
  output reg [3:0] io,
  // device data
  input wire [3:0] io_out
);
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    io   = 4'h0;
  end
  // mode 0: data set while sck low
  task tick(input [3:0] v);
    begin
      io = v;
      #24 sck = 1'b1;
      #24 sck = 1'b0;
    end
  endtask
  task quad(input [31:0] v, input integer n);
    integer i;
    begin
      for (i = n - 1; i >= 0; i = i - 1) tick(v[4*i+:4]);
    end
  endtask
  // select only: continuous frames start straight at the address
  task open_frame;
    begin
      cs_n = 1'b0;
      #24;
    end
  endtask
  task frame(input [7:0] op, input quad_instruction_mode);
    integer i;
    begin
      cs_n = 1'b0;
      #24;
      if (quad_instruction_mode) quad({24'h0, op}, 2);
      else for (i = 7; i >= 0; i = i - 1) tick({~io[3:1], op[i]});
    end
  endtask
  // lines released: toggle so no stale value reads as data
  task rd_byte(output [7:0] d);
    begin
      io = ~io;
      #24 d[7:4] = io_out;
      sck = 1'b1;
      #24 sck = 1'b0;
      io = ~io;
      #24 d[3:0] = io_out;
      sck = 1'b1;
      #24 sck = 1'b0;
    end
  endtask
  task end_frame;
    begin
      #24 cs_n = 1'b1;
      io = ~io;
      #48;
    end
  endtask
endmodule

/* File: bench/qrw_ctrl_chk.sv */
`timescale 1ns/1ps
module qrw_ctrl_chk #(
  parameter RESET_RECOVERY_CYCLES = 6000
) (
  input wire       MCLK,
  input wire       RESETN,
  input wire       CS_N,
  input wire       QUAD_ENABLE,
  input wire       QPI_MODE,
  input wire [3:0] IO_OE_N,
  input wire       ARRAY_RD,
  input wire       WRAP_DISABLE,
  input wire [1:0] WRAP_LENGTH,
  input wire [1:0] DUMMY_SELECT,
  input wire       CONT_READ,
  input wire       SW_RESET,
  input wire       RESET_BUSY
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  reg [15:0] busy_cnt;
  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN)
      busy_cnt <= 16'h0000;
    else if (RESET_BUSY)
      busy_cnt <= busy_cnt + 16'h0001;
    else
      busy_cnt <= 16'h0000;
  end
  // ==========================================================
  // properties
  a_sw_pulse: assert property (SW_RESET |=> !SW_RESET)
    else $error("reset pulse too long");
  a_busy_start: assert property (SW_RESET |-> ##[0:1] RESET_BUSY)
    else $error("busy did not start");
  a_busy_len: assert property ($fell(RESET_BUSY) |-> busy_cnt == RESET_RECOVERY_CYCLES)
    else $error("busy length wrong");
  a_busy_quiet: assert property (RESET_BUSY |-> !ARRAY_RD)
    else $error("read during recovery");
  a_rst_defaults: assert property (SW_RESET |-> ##[0:1] (WRAP_DISABLE && !CONT_READ
    && WRAP_LENGTH == 2'h0 && DUMMY_SELECT == 2'h0))
    else $error("defaults not restored");
  a_wrap_qe: assert property ($fell(WRAP_DISABLE) |-> QUAD_ENABLE)
    else $error("wrap set without quad enable");
  a_param_qpi: assert property ($rose(DUMMY_SELECT[1]) |-> QPI_MODE)
    else $error("parameters set in serial mode");
  a_rd_pulse: assert property (ARRAY_RD |=> !ARRAY_RD)
    else $error("read pulse too long");
  a_oe_idle: assert property (CS_N [*8] |-> IO_OE_N == 4'hf)
    else $error("driving while deselected");
endmodule
bind qrw_ctrl qrw_ctrl_chk #(.RESET_RECOVERY_CYCLES(RESET_RECOVERY_CYCLES)) u_chk (
  .MCLK(MCLK), .RESETN(RESETN), .CS_N(CS_N), .QUAD_ENABLE(QUAD_ENABLE),
  .QPI_MODE(QPI_MODE), .IO_OE_N(IO_OE_N), .ARRAY_RD(ARRAY_RD),
  .WRAP_DISABLE(WRAP_DISABLE), .WRAP_LENGTH(WRAP_LENGTH), .DUMMY_SELECT(DUMMY_SELECT),
  .CONT_READ(CONT_READ), .SW_RESET(SW_RESET), .RESET_BUSY(RESET_BUSY));

/* File: bench/qrw_ctrl_bench.sv */
`timescale 1ns/1ps
module qrw_ctrl_bench;
  reg         MCLK = 1'b0;
  reg         RESETN = 1'b0;
  reg         QUAD_ENABLE = 1'b0;
  reg         QPI_MODE = 1'b0;
  wire        cs_n, sck, ARRAY_RD, wdis, cont, swr, busy;
  wire [3:0]  io_in, IO_OUT, IO_OE_N;
  wire [1:0]  wlen, dsel;
  wire [23:0] ARRAY_ADDR;
  wire [7:0]  ARRAY_DATA = ARRAY_ADDR[7:0] ^ 8'h5a;
  integer     error_cnt = 0;
  integer     samples_checked = 0;
  integer     sw_seen = 0;
  integer     rd_seen = 0;
  integer     i;
  reg [7:0]   d;
  always #2.5 MCLK = ~MCLK;
  always @(posedge MCLK) if (swr === 1'b1) sw_seen = sw_seen + 1;
  always @(posedge MCLK) if (ARRAY_RD === 1'b1) rd_seen = rd_seen + 1;
  qrw_ctrl #(.RESET_RECOVERY_CYCLES(400)) dut (.MCLK(MCLK), .RESETN(RESETN), .CS_N(cs_n),
    .SCK(sck), .IO_IN(io_in), .IO_OUT(IO_OUT), .IO_OE_N(IO_OE_N), .QUAD_ENABLE(QUAD_ENABLE),
    .QPI_MODE(QPI_MODE), .ARRAY_ADDR(ARRAY_ADDR), .ARRAY_DATA(ARRAY_DATA), .ARRAY_RD(ARRAY_RD),
    .WRAP_DISABLE(wdis), .WRAP_LENGTH(wlen), .DUMMY_SELECT(dsel), .CONT_READ(cont),
    .SW_RESET(swr), .RESET_BUSY(busy));
  qrw_host host (.cs_n(cs_n), .sck(sck), .io(io_in), .io_out(IO_OUT));
  task check(input [63:0] what, input [7:0] seen, input [7:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task wrap_cmd(input [7:0] w);
    begin
      host.frame(8'h77, 1'b0);
      host.quad(32'h0, 6);
      host.quad({24'h0, w}, 2);
      host.end_frame;
    end
  endtask
  task param_cmd(input [7:0] p, input q);
    begin
      host.frame(8'hc0, q);
      host.quad({24'h0, p}, 2);
      host.end_frame;
    end
  endtask
  // ==========================================================
  // scenarios
  task t_wrap;
    begin
      check("wdis", wdis, 1);
      check("dsel", dsel, 0);
      check("wlen", wlen, 0);
      wrap_cmd(8'h40);
      check("wdis", wdis, 1);
      @(negedge MCLK) QUAD_ENABLE = 1'b1;
      wrap_cmd(8'hc6); // stray bits 7 and 2:1 must be ignored
      check("wdis", wdis, 0);
      check("wlen", wlen, 2);
    end
  endtask
  task t_param;
    begin
      param_cmd(8'h31, 1'b0);
      check("dsel", dsel, 0);
      @(negedge MCLK) QPI_MODE = 1'b1;
      check("wlen", wlen, 2);
      param_cmd(8'h31, 1'b1);
      check("dsel", dsel, 3);
      check("wlen", wlen, 1);
      param_cmd(8'h22, 1'b1);
      check("dsel", dsel, 2);
      @(negedge MCLK) QPI_MODE = 1'b0;
    end
  endtask
  task t_read;
    begin
      host.frame(8'he7, 1'b0);
      host.quad(32'h00103e, 6);
      host.quad(32'ha500, 4); // mode a5, then two dummies
      for (i = 0; i < 4; i = i + 1) begin
        host.rd_byte(d);
        check("data", d, (((8'h3e + i) & 8'h1f) | 8'h20) ^ 8'h5a);
      end
      check("oe", IO_OE_N, 0);
      host.end_frame;
      check("rd", rd_seen, 4);
      check("cont", cont, 1);
      host.open_frame;
      host.quad(32'h000078, 6);
      host.quad(32'h0000, 4); // mode 00 ends continuous mode
      host.rd_byte(d);
      check("data", d, 8'h22);
      host.end_frame;
      check("cont", cont, 0);
      @(negedge MCLK) QUAD_ENABLE = 1'b0;
      host.frame(8'he7, 1'b0);
      host.quad(32'h001040a5, 8);
      host.quad(32'h0, 2);
      host.rd_byte(d);
      check("oe", IO_OE_N, 4'hf);
      host.end_frame;
      @(negedge MCLK) QUAD_ENABLE = 1'b1;
    end
  endtask
  task t_burst;
    begin
      @(negedge MCLK) QPI_MODE = 1'b1;
      host.frame(8'h0c, 1'b1);
      host.quad(32'h00005e, 6);
      host.quad(32'h0, 6);
      for (i = 0; i < 3; i = i + 1) begin
        host.rd_byte(d);
        check("data", d, (((8'h5e + i) & 8'h1f) | 8'h40) ^ 8'h5a);
      end
      host.end_frame;
      @(negedge MCLK) QPI_MODE = 1'b0;
    end
  endtask
  task t_reset;
    begin
      host.frame(8'h66, 1'b0);
      host.end_frame;
      param_cmd(8'h31, 1'b0);
      host.frame(8'h99, 1'b0);
      host.end_frame;
      check("swr", sw_seen, 0);
      check("dsel", dsel, 2);
      @(negedge MCLK) QPI_MODE = 1'b1;
      host.frame(8'h66, 1'b1);
      host.end_frame;
      host.frame(8'h99, 1'b1);
      host.end_frame;
      @(negedge MCLK) QPI_MODE = 1'b0;
      check("swr", sw_seen, 1);
      check("dsel", dsel, 0);
      check("wdis", wdis, 1);
      check("busy", busy, 1);
      wrap_cmd(8'h40);
      check("wdis", wdis, 1);
      for (i = 0; i < 800 && busy !== 1'b0; i = i + 1) @(posedge MCLK);
      check("busy", busy, 0);
    end
  endtask
  task tally_and_finish;
    begin
      $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    repeat (2) @(negedge MCLK);
    RESETN = 1'b1;
    repeat (5) @(negedge MCLK);
    t_wrap;
    t_param;
    t_read;
    t_burst;
    t_reset;
    tally_and_finish;
  end
  // whole run is about 11 us of frames
  initial begin
    #300000;
    error_cnt = error_cnt + 1;
    tally_and_finish;
  end
endmodule
